// File: qot_pkg.sv
// package: constants and types for the quadrature and one-shot timer channel
package qot_pkg;
  // ---------------------------------------------------------------------------
  // widths and values
  // ---------------------------------------------------------------------------
  localparam int          CNT_W      = 16;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] RST_VAL    = 16'h0000;
  // value seen on a read in one-shot mode, where the count is not readable
  localparam logic [15:0] RD_INDET   = 16'hFFFF;

  // ---------------------------------------------------------------------------
  // channel flavours of two-phase processing
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    QOT_PROC_SELECT = 2'b00,
    QOT_PROC_NORMAL = 2'b01,
    QOT_PROC_X4     = 2'b10
  } qot_proc_e;
endpackage

// File: qot_timer.sv
// module: one 16-bit timer channel, two-phase event counter and one-shot modes
//
// Summary of operation
// RULE1: two-phase counting uses both channel pins
// RULE2: over/underflow reloads reload value, keeps counting
// RULE3: free-run option suppresses the reload
// RULE4: up count divides by FFFF minus n plus one
// RULE5: down count divides by n plus one
// RULE6: counting runs while start flag is one
// RULE7: interrupt request on each over/underflow
// RULE8: event mode read returns live count
// RULE9: write loads both when stopped, else reload
// RULE10: normal mode counts input edges while output high
// RULE11: multiply-by-4 counts every edge of both pins
// RULE12: one channel selectable, others fixed processing
// RULE13: one-shot counts down, reloads at zero, stops
// RULE14: trigger while counting reloads and restarts
// RULE15: start by trigger pin, timer overflow, software
// RULE16: one-shot stops at zero or flag cleared
// RULE17: one-shot interrupt request when count reaches zero
// RULE18: one-shot read returns indeterminate value
// RULE19: one-shot write loads both when stopped, else reload
// RULE20: one-shot pins are trigger input and pulse output
// RULE21: free-run counts through without reloading
// RULE22: pulse output active while one-shot count runs
module qot_timer #(
  parameter qot_pkg::qot_proc_e PROC_KIND = qot_pkg::QOT_PROC_SELECT
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        mode_oneshot,
  input  wire logic        count_start,
  input  wire logic        oneshot_start,
  input  wire logic        free_run,
  input  wire logic        x4_sel,
  input  wire logic        trig_pin_en,
  input  wire logic        trig_ovf_en,
  input  wire logic        timer_ovf_in,
  input  wire logic        pulse_out_en,
  input  wire logic        count_tick,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data,
  output logic             irq,
  input  wire logic        channel_input_pin,
  input  wire logic        channel_output_pin_i,
  output logic             channel_output_pin_o,
  output logic             channel_output_pin_oe
);
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        in_d;
    logic        out_d;
    logic [15:0] counter;
    logic [15:0] reload;
    logic        running;
    logic        pulse;
    logic        irq;
    logic [15:0] rd;
  } qot_state_s;

  qot_state_s st_reg;
  qot_state_s st_next;

  // ---------------------------------------------------------------------------
  // edge decoding
  // ---------------------------------------------------------------------------
  // returns {up, down} for one sample of the pin pair
  function automatic logic [1:0] qot_dir(input logic a_p, input logic a,
                                         input logic b_p, input logic b,
                                         input logic x4);
    logic a_r;
    logic a_f;
    logic b_r;
    logic b_f;
    logic up;
    logic dn;
    a_r = a & ~a_p;
    a_f = ~a & a_p;
    b_r = b & ~b_p;
    b_f = ~b & b_p;
    if (x4) begin
      // every edge of both pins counts; direction from the phase relation
      up = (a_r & b) | (a_f & ~b) | (b_r & ~a) | (b_f & a);  // RULE11
      dn = (a_f & b) | (a_r & ~b) | (b_r & a) | (b_f & ~a);  // RULE11
    end else begin
      // only input-pin edges, gated by the output-side pin being high
      up = a_r & b;  // RULE10
      dn = a_f & b;  // RULE10
    end
    return {up, dn};
  endfunction

  // processing is fixed per channel flavour; only one flavour honours x4_sel
  logic use_x4;
  always_comb begin
    unique case (PROC_KIND)
      qot_pkg::QOT_PROC_NORMAL: use_x4 = 1'b0;  // RULE12
      qot_pkg::QOT_PROC_X4:     use_x4 = 1'b1;  // RULE12
      default:                  use_x4 = x4_sel;  // RULE12
    endcase
  end

  // both pins are inputs in event mode
  logic [1:0] dir;
  assign dir = qot_dir(st_reg.in_d, channel_input_pin, st_reg.out_d,
                       channel_output_pin_i, use_x4);  // RULE1

  // any enabled trigger source while the count start flag is set
  logic trig;
  assign trig = count_start & (oneshot_start
              | (trig_pin_en & channel_input_pin & ~st_reg.in_d)
              | (trig_ovf_en & timer_ovf_in));  // RULE15 RULE20

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.in_d  = channel_input_pin;
    st_next.out_d = channel_output_pin_i;
    st_next.irq   = 1'b0;
    if (!mode_oneshot) begin
      st_next.running = 1'b0;
      st_next.pulse   = 1'b0;
      // write: both when stopped, reload only while counting
      if (wr_en) begin
        st_next.reload = wr_data;  // RULE9
        if (!count_start) begin
          st_next.counter = wr_data;  // RULE9
        end
      end
      if (count_start && dir[1]) begin  // RULE6
        if (st_reg.counter == qot_pkg::CNT_MAX) begin
          // overflow: period is FFFF - n + 1 counts
          st_next.irq     = 1'b1;  // RULE7
          st_next.counter = free_run ? qot_pkg::CNT_ZERO : st_reg.reload;  // RULE2 RULE3 RULE4 RULE21
        end else begin
          st_next.counter = st_reg.counter + qot_pkg::CNT_ONE;
        end
      end else if (count_start && dir[0]) begin  // RULE6
        if (st_reg.counter == qot_pkg::CNT_ZERO) begin
          // underflow: period is n + 1 counts
          st_next.irq     = 1'b1;  // RULE7
          st_next.counter = free_run ? qot_pkg::CNT_MAX : st_reg.reload;  // RULE2 RULE3 RULE5 RULE21
        end else begin
          st_next.counter = st_reg.counter - qot_pkg::CNT_ONE;
        end
      end
      st_next.rd = st_next.counter;  // RULE8
    end else begin
      if (wr_en) begin
        st_next.reload = wr_data;  // RULE19
        if (!st_reg.running) begin
          st_next.counter = wr_data;  // RULE19
        end
      end
      if (!count_start) begin
        st_next.running = 1'b0;  // RULE16
      end else if (trig) begin
        // a trigger mid-count restarts from the reload value
        st_next.counter = wr_en ? wr_data : st_reg.reload;  // RULE14
        st_next.running = 1'b1;  // RULE15
      end else if (st_reg.running && count_tick) begin
        if (st_reg.counter <= qot_pkg::CNT_ONE) begin
          // reaching zero: request, reload, then stop
          st_next.irq     = 1'b1;  // RULE17
          st_next.counter = wr_en ? wr_data : st_reg.reload;  // RULE13
          st_next.running = 1'b0;  // RULE13 RULE16
        end else begin
          st_next.counter = st_reg.counter - qot_pkg::CNT_ONE;  // RULE13
        end
      end
      st_next.pulse = st_next.running;  // RULE22
      st_next.rd    = qot_pkg::RD_INDET;  // RULE18
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{in_d: 1'b0, out_d: 1'b0, counter: qot_pkg::RST_VAL,
                  reload: qot_pkg::RST_VAL, running: 1'b0, pulse: 1'b0,
                  irq: 1'b0, rd: qot_pkg::RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  // output pin is only driven as a pulse output in one-shot mode
  assign rd_data               = st_reg.rd;
  assign irq                   = st_reg.irq;
  assign channel_output_pin_o  = st_reg.pulse;  // RULE22
  assign channel_output_pin_oe = mode_oneshot & pulse_out_en;  // RULE1 RULE20

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_up_overflow: assert property (  // RULE2
    !mode_oneshot && count_start && dir[1] && !free_run && !wr_en
    && st_reg.counter == qot_pkg::CNT_MAX
    |=> irq && st_reg.counter == $past(st_reg.reload))
    else $error("overflow did not reload and request");
  chk_free_wrap: assert property (  // RULE21
    !mode_oneshot && count_start && dir[0] && free_run
    && st_reg.counter == qot_pkg::CNT_ZERO |=> st_reg.counter == qot_pkg::CNT_MAX && irq)
    else $error("free-run underflow did not wrap");
  chk_halt_cnt: assert property (  // RULE6
    !mode_oneshot && !count_start && !wr_en |=> $stable(st_reg.counter) && !irq)
    else $error("event counter moved while halted");
  chk_event_rd: assert property (  // RULE8
    !mode_oneshot && count_start && dir[1] && st_reg.counter != qot_pkg::CNT_MAX
    |=> rd_data == 16'($past(st_reg.counter) + qot_pkg::CNT_ONE))
    else $error("read does not show count");
  chk_wr_stopped: assert property (  // RULE9
    !mode_oneshot && !count_start && wr_en |=> st_reg.counter == $past(wr_data))
    else $error("stopped write missed counter");
  chk_wr_running: assert property (  // RULE19
    mode_oneshot && st_reg.running && count_start && wr_en && !trig && !count_tick
    |=> st_reg.counter == $past(st_reg.counter) && st_reg.reload == $past(wr_data))
    else $error("running write touched counter");
  chk_os_done: assert property (  // RULE17
    mode_oneshot && st_reg.running && count_start && !trig && count_tick
    && st_reg.counter == qot_pkg::CNT_ONE |=> irq ##1 !irq && !st_reg.running)
    else $error("one-shot end not flagged");
  chk_os_trig: assert property (  // RULE14
    mode_oneshot && trig && !wr_en |=> st_reg.running
    && st_reg.counter == $past(st_reg.reload))
    else $error("trigger did not restart");
  chk_os_stop: assert property (  // RULE16
    mode_oneshot && !count_start |=> !st_reg.running && !channel_output_pin_o)
    else $error("one-shot kept running");
  chk_os_read: assert property (  // RULE18
    mode_oneshot |=> rd_data == qot_pkg::RD_INDET)
    else $error("one-shot read leaked count");

  // ---------------------------------------------------------------------------
  // checks: pin decoding and event counting steps
  // ---------------------------------------------------------------------------
  // normal processing ignores every edge while the other pin is low
  chk_normal_gate: assert property (  // RULE10
    !mode_oneshot && !use_x4 && !channel_output_pin_i && !wr_en
    |=> $stable(st_reg.counter) && !irq)
    else $error("normal processing counted with other pin low");
  // one pin moving alone is exactly one count in multiply-by-4 processing
  chk_x4_edges: assert property (  // RULE11
    !mode_oneshot && use_x4
    && ((channel_input_pin ^ st_reg.in_d) != (channel_output_pin_i ^ st_reg.out_d))
    |-> $onehot(dir))
    else $error("multiply-by-4 missed a single pin edge");
  // counting up between wrap points moves the count by one
  chk_up_step: assert property (  // RULE4
    !mode_oneshot && count_start && dir[1] && st_reg.counter != qot_pkg::CNT_MAX
    |=> st_reg.counter == 16'($past(st_reg.counter) + qot_pkg::CNT_ONE) && !irq)
    else $error("up count did not advance by one");
  // counting down between wrap points moves the count by one
  chk_down_step: assert property (  // RULE5
    !mode_oneshot && count_start && !dir[1] && dir[0] && st_reg.counter != qot_pkg::CNT_ZERO
    |=> st_reg.counter == 16'($past(st_reg.counter) - qot_pkg::CNT_ONE) && !irq)
    else $error("down count did not step back by one");
  // underflow in reload mode starts the next period from the reload value
  chk_down_reload: assert property (  // RULE2
    !mode_oneshot && count_start && !dir[1] && dir[0] && !free_run && !wr_en
    && st_reg.counter == qot_pkg::CNT_ZERO
    |=> irq && st_reg.counter == $past(st_reg.reload))
    else $error("underflow did not reload and request");
  // a request in event mode always has a counted wrap behind it
  chk_irq_cause: assert property (  // RULE7
    !mode_oneshot && !(count_start && dir[1] && st_reg.counter == qot_pkg::CNT_MAX)
    && !(count_start && !dir[1] && dir[0] && st_reg.counter == qot_pkg::CNT_ZERO)
    |=> !irq)
    else $error("event interrupt without a wrap");
  // both channel pins stay inputs while counting events
  chk_event_oe: assert property (  // RULE1
    !mode_oneshot |-> !channel_output_pin_oe)
    else $error("output pin driven in event mode");

  // ---------------------------------------------------------------------------
  // checks: one-shot starting, counting and pulse output
  // ---------------------------------------------------------------------------
  // an enabled external source starts the count and the pulse output
  chk_os_start: assert property (  // RULE15
    mode_oneshot && count_start && (trig_ovf_en && timer_ovf_in
    || trig_pin_en && channel_input_pin && !st_reg.in_d)
    |=> st_reg.running && channel_output_pin_o)
    else $error("external trigger did not start");
  // each tick above one takes one off the running count
  chk_os_step: assert property (  // RULE13
    mode_oneshot && st_reg.running && count_start && !trig && count_tick
    && st_reg.counter > qot_pkg::CNT_ONE
    |=> st_reg.running && st_reg.counter == 16'($past(st_reg.counter) - qot_pkg::CNT_ONE))
    else $error("one-shot tick did not step down");
  // a stopped one-shot holds its count and stays quiet until triggered
  chk_os_idle: assert property (  // RULE16
    mode_oneshot && !st_reg.running && !trig && !wr_en
    |=> $stable(st_reg.counter) && !irq && !channel_output_pin_o)
    else $error("stopped one-shot moved");
  // the pulse output has dropped by the time the end request shows
  chk_os_pulse: assert property (  // RULE22
    mode_oneshot && irq |-> !channel_output_pin_o && !st_reg.running)
    else $error("pulse output outlived the count");
endmodule

// File: qot_enc.sv
// partner model: two-phase encoder that drives both channel pins
module qot_enc (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic step,
  input  wire logic dir,
  output logic      pin_a,
  output logic      pin_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph_reg;
  // gray order, so only one pin moves per step and no glitch is counted
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ph_reg <= 2'h0;
    end else if (step) begin
      ph_reg <= dir ? ph_reg + 2'h1 : ph_reg - 2'h1;
    end
  end
  assign pin_a = ph_reg[1];
  assign pin_b = ph_reg[1] ^ ph_reg[0];
endmodule

// File: tb.sv
// testbench: event counting and one-shot runs of the timer channel
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // signals
  // ----
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        mode_oneshot, count_start, oneshot_start, free_run, x4_sel;
  logic        trig_pin_en, trig_ovf_en, timer_ovf_in, pulse_out_en;
  logic        count_tick, wr_en, step, dir, irq, pin_a, pin_b, pin_o, pin_oe;
  logic [15:0] wr_data, rd_data;
  logic [15:0] exp_q[$];
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          n, m;

  always #10 core_clk = ~core_clk;

  qot_timer dut (.core_clk(core_clk), .rstn(rstn), .mode_oneshot(mode_oneshot),
    .count_start(count_start), .oneshot_start(oneshot_start), .free_run(free_run),
    .x4_sel(x4_sel), .trig_pin_en(trig_pin_en), .trig_ovf_en(trig_ovf_en),
    .timer_ovf_in(timer_ovf_in), .pulse_out_en(pulse_out_en), .count_tick(count_tick),
    .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .irq(irq),
    .channel_input_pin(pin_a), .channel_output_pin_i(pin_b),
    .channel_output_pin_o(pin_o), .channel_output_pin_oe(pin_oe));

  qot_enc enc (.core_clk(core_clk), .rstn(rstn), .step(step), .dir(dir),
    .pin_a(pin_a), .pin_b(pin_b));

  // ----
  // tasks
  // ----
  task automatic cyc();
    @(posedge core_clk);
    #2;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // encoder steps back to back, then let the pin samples settle
  task automatic steps(input int k, input logic d);
    step = 1'b1;
    dir = d;
    repeat (k) cyc();
    step = 1'b0;
    repeat (3) cyc();
  endtask

  task automatic ticks(input int k);
    repeat (k) begin
      count_tick = 1'b1;
      cyc();
      count_tick = 1'b0;
      cyc();
    end
  endtask

  task automatic write(input logic [15:0] v);
    wr_data = v;
    wr_en = 1'b1;
    cyc();
    wr_en = 1'b0;
    repeat (2) cyc();
  endtask

  task automatic trig();
    oneshot_start = 1'b1;
    cyc();
    oneshot_start = 1'b0;
    repeat (2) cyc();
  endtask

  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // each interrupt takes the oldest noted value; one with no note is a mismatch
  always @(posedge core_clk) begin
    if (irq === 1'b1) begin
      if (exp_q.size() == 0) check(16'(irq), 16'h0000, "stray_irq");
      else check(rd_data, exp_q.pop_front(), "irq_value");
    end
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end

  // ----
  // main sequence
  // ----
  initial begin
    {mode_oneshot, count_start, oneshot_start, free_run, x4_sel, trig_pin_en} = '0;
    {trig_ovf_en, timer_ovf_in, pulse_out_en, count_tick, wr_en, step, dir} = '0;
    wr_data = 16'h0000;
    void'($urandom(32'h2f6d));
    repeat (6) cyc();
    rstn = 1'b1;
    x4_sel = 1'b1;
    pulse_out_en = 1'b1;
    write(16'hFFFE);
    check(rd_data, 16'hFFFE, "stopped_write");
    check(16'(pin_oe), 16'h0000, "event_oe");
    count_start = 1'b1;
    exp_q.push_back(16'hFFFE);
    steps(2, 1'b1);
    write(16'h0003);
    check(rd_data, 16'hFFFE, "running_write");
    exp_q.push_back(16'h0003);
    steps(2, 1'b1);
    exp_q.push_back(16'h0003);
    steps(4, 1'b0);
    count_start = 1'b0;
    // a halted counter ignores edges under a randomly picked processing option
    x4_sel = 1'($urandom_range(1, 0));
    steps(2, 1'b0);
    check(rd_data, 16'h0003, "halted");
    x4_sel = 1'b1;
    // both wrap options, in random order, each from a stopped load of 3
    m = $urandom_range(1, 0);
    for (int k = 0; k < 2; k++) begin
      write(16'h0003);
      free_run = 1'(m + k);
      count_start = 1'b1;
      exp_q.push_back(free_run ? 16'hFFFF : 16'h0003);
      steps(4, 1'b0);
      count_start = 1'b0;
    end
    // normal processing: one count per full encoder cycle, on the input rise
    write(16'hFFFF);
    free_run = 1'b0;
    x4_sel = 1'b0;
    count_start = 1'b1;
    exp_q.push_back(16'hFFFF);
    steps(4, 1'b1);
    steps(3, 1'b1);
    check(rd_data, 16'hFFFF, "normal_hold");
    // one-shot with each of the three trigger sources
    mode_oneshot = 1'b1;
    for (int k = 0; k < 3; k++) begin
      n = $urandom_range(5, 2);
      count_start = 1'b0;
      write(16'(n));
      check(rd_data, 16'hFFFF, "oneshot_read");
      count_start = 1'b1;
      pulse_out_en = 1'(k + $urandom_range(1, 0));
      trig_pin_en = (k == 2);
      trig_ovf_en = (k == 1);
      if (k == 0) begin
        trig();
      end else if (k == 1) begin
        timer_ovf_in = 1'b1;
        cyc();
        timer_ovf_in = 1'b0;
      end else begin
        steps(4, 1'b1);
      end
      repeat (3) cyc();
      check(16'(pin_o), 16'h0001, "pulse_active");
      check(16'(pin_oe), 16'(pulse_out_en), "pulse_enable");
      ticks(n - 1);
      exp_q.push_back(16'hFFFF);
      ticks(1);
      repeat (3) cyc();
      check(16'(pin_o), 16'h0000, "pulse_done");
      ticks(2);
    end
    // write while running, then retrigger picks up the new reload
    trig_pin_en = 1'b0;
    trig_ovf_en = 1'b0;
    n = $urandom_range(5, 3);
    count_start = 1'b0;
    write(16'(n));
    count_start = 1'b1;
    trig();
    ticks(1);
    m = n + 2;
    write(16'(m));
    ticks(n - 2);
    exp_q.push_back(16'hFFFF);
    ticks(1);
    trig();
    ticks(1);
    trig();
    ticks(m - 1);
    exp_q.push_back(16'hFFFF);
    ticks(1);
    // clearing the start flag ends a run with no interrupt
    trig();
    count_start = 1'b0;
    repeat (3) cyc();
    check(16'(pin_o), 16'h0000, "flag_stop");
    // a software start is refused while the start flag is clear
    trig();
    check(16'(pin_o), 16'h0000, "refused_start");
    ticks(m + 1);
    check(16'(exp_q.size()), 16'h0000, "pending_irq");
    give_verdict();
  end
endmodule
